/* wit_defines.svh */
`ifndef WIT_DEFINES_SVH
`define WIT_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define WIT_CTL_INDEX 10'h0C9
`define WIT_STAT_INDEX 10'h0CA

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define WIT_KEY_HI 7
`define WIT_KEY_LO 4
`define WIT_RUN_BIT 3
`define WIT_MODE_BIT 2
`define WIT_SEL_HI 1
`define WIT_SEL_LO 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define WIT_KEY_RESET 4'h0
`define WIT_SEL_RESET 2'h0
`define WIT_CNT_RESET 15'h0000
`define WIT_KEY_ARM 4'hA
`define WIT_KEY_FIRE 4'h5

// ----------------------------------------
// Last count of each interval, in low-speed periods
// ----------------------------------------
`define WIT_LAST_32768 15'h7FFF
`define WIT_LAST_8192 15'h1FFF
`define WIT_LAST_512 15'h01FF
`define WIT_LAST_64 15'h003F

`endif

/* wit_pkg.sv */
package wit_pkg;

   // ----------------------------------------
   // Power modes and clear key window states
   // ----------------------------------------
   typedef enum logic [2:0] {
      WIT_PWR_ACTIVE,
      WIT_SLEEP_LEVEL_ZERO,
      WIT_SLEEP_LEVEL_ONE,
      WIT_SLEEP_LEVEL_TWO,
      WIT_SLEEP_LEVEL_THREE
   } wit_pwr_t;

   typedef enum logic {
      WIT_KEY_IDLE,
      WIT_KEY_ARMED
   } wit_key_t;

endpackage : wit_pkg

/* wit_watchdog.sv */
`timescale 1ns/1ps
`include "wit_defines.svh"
// Overview of operation
// - Hidden 15-bit counter on low-speed clock
// - Deepest sleep modes force counter to zero
// - Timer disabled after reset
// - Watchdog mode starts counting when run set
// - Running watchdog ignores run bit cleared
// - Running watchdog locks mode, interval stays writable
// - Four intervals: 64, 512, 8192, 32768 periods
// - Select 00,01,10,11 gives 32768,8192,512,64
// - Watchdog timeout asserts system reset
// - Key 1010 then 0101 within half period
// - Complete sequence before timeout clears counter
// - Clear key ignored while run is zero
// - Watchdog mode never raises timer interrupt
// - Timer mode expiry sets flag, gated interrupt
// - Timer mode key bit zero clears counter
// - Timer run low stops, high restarts zero
// - Timer mode never resets the system
// - Active and lightest mode reset on timeout
// - First sleep level defers reset until wake
// - Deep sleep stops, keeps configuration, restarts zero
// - Control layout key, run, mode, interval
module wit_watchdog (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Low-speed oscillator
   input wire logic lsclk,
   // Power mode from power controller
   input wire logic [2:0] pwr_mode,
   // Interrupt controller
   input wire logic timeout_irq_allow,
   output logic timeout_flag,
   output logic irq_req,
   // System reset request
   output logic sys_reset_req
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic wit_hit(input logic [11:0] addr, input logic [9:0] index);
      wit_hit = (addr == {index, 2'b00});
   endfunction : wit_hit

   function automatic logic [14:0] wit_last(input logic [1:0] sel);
      case (sel)
         2'h0: wit_last = `WIT_LAST_32768;
         2'h1: wit_last = `WIT_LAST_8192;
         2'h2: wit_last = `WIT_LAST_512;
         default: wit_last = `WIT_LAST_64;
      endcase
   endfunction : wit_last

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic ls_meta;
   logic ls_sync;
   logic ls_prev;
   logic tick;
   logic ls_edge;
   logic [3:0] key_field;
   logic run;
   logic mode;
   logic [1:0] sel;
   logic [14:0] cnt;
   logic [14:0] limit;
   wit_pkg::wit_key_t key_state;
   logic doze_miss;
   logic deep;
   logic doze;
   logic awake;
   logic setup;
   logic ctl_wr;
   logic wd_locked;
   logic start_req;
   logic arm_req;
   logic fire_req;
   logic tclear_req;
   logic key_lapse;
   logic expire;
   logic wd_timeout;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // Low-speed clock sync and edges
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_meta <= 1'b0;
         ls_sync <= 1'b0;
         ls_prev <= 1'b0;
      end else begin
         ls_meta <= lsclk;
         ls_sync <= ls_meta;
         ls_prev <= ls_sync;
      end
   end

   assign tick = ls_sync & ~ls_prev;
   assign ls_edge = ls_sync ^ ls_prev;

   // ----------------------------------------
   // Power mode decode
   // ----------------------------------------
   assign deep = (pwr_mode == wit_pkg::WIT_SLEEP_LEVEL_TWO) ||
                 (pwr_mode == wit_pkg::WIT_SLEEP_LEVEL_THREE);
   assign doze = (pwr_mode == wit_pkg::WIT_SLEEP_LEVEL_ONE);
   assign awake = ~deep & ~doze;

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   assign setup = psel & ~penable;
   assign ctl_wr = psel & penable & pwrite & pready & wit_hit(paddr, `WIT_CTL_INDEX);
   assign wd_locked = run & ~mode;
   assign start_req = ctl_wr & ~wd_locked & pwdata[`WIT_RUN_BIT] & ~run;
   assign arm_req = ctl_wr & run & ~mode &
                    (pwdata[`WIT_KEY_HI:`WIT_KEY_LO] == `WIT_KEY_ARM);
   assign fire_req = ctl_wr & run & ~mode & (key_state == wit_pkg::WIT_KEY_ARMED) &
                     (pwdata[`WIT_KEY_HI:`WIT_KEY_LO] == `WIT_KEY_FIRE);
   assign tclear_req = ctl_wr & run & mode & pwdata[`WIT_KEY_LO];

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_field <= `WIT_KEY_RESET;
         run <= 1'b0;
         mode <= 1'b0;
         sel <= `WIT_SEL_RESET;
      end else if (ctl_wr) begin
         sel <= pwdata[`WIT_SEL_HI:`WIT_SEL_LO];
         if (!wd_locked) begin
            mode <= pwdata[`WIT_MODE_BIT];
            run <= pwdata[`WIT_RUN_BIT];
         end
         if (run) begin
            key_field <= pwdata[`WIT_KEY_HI:`WIT_KEY_LO];
         end
      end
   end

   // ----------------------------------------
   // Clear key window
   // ----------------------------------------
   assign key_lapse = (key_state == wit_pkg::WIT_KEY_ARMED) & ls_edge & ~fire_req &
                      ~arm_req & ~deep;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_state <= wit_pkg::WIT_KEY_IDLE;
      end else begin
         case (key_state)
            wit_pkg::WIT_KEY_IDLE: begin
               if (arm_req && !deep) begin
                  key_state <= wit_pkg::WIT_KEY_ARMED;
               end
            end
            wit_pkg::WIT_KEY_ARMED: begin
               if (deep || fire_req || key_lapse) begin
                  key_state <= wit_pkg::WIT_KEY_IDLE;
               end
            end
            default: begin
               key_state <= wit_pkg::WIT_KEY_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   assign limit = wit_last(sel);
   assign expire = run & ~deep & tick & (cnt == limit);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= `WIT_CNT_RESET;
      end else if (deep) begin
         cnt <= `WIT_CNT_RESET;
      end else if (start_req || fire_req || tclear_req) begin
         cnt <= `WIT_CNT_RESET;
      end else if (run && tick) begin
         if (expire) begin
            cnt <= `WIT_CNT_RESET;
         end else begin
            cnt <= cnt + 15'h0001;
         end
      end
   end

   // ----------------------------------------
   // System reset
   // ----------------------------------------
   assign wd_timeout = ~mode & (expire | key_lapse);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         doze_miss <= 1'b0;
      end else if (deep || awake) begin
         doze_miss <= 1'b0;
      end else if (wd_timeout) begin
         doze_miss <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_req <= 1'b0;
      end else begin
         sys_reset_req <= awake & (wd_timeout | doze_miss);
      end
   end

   // ----------------------------------------
   // Timer interrupt
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_flag <= 1'b0;
         irq_req <= 1'b0;
      end else begin
         timeout_flag <= expire & mode;
         irq_req <= expire & mode & timeout_irq_allow;
      end
   end

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~wit_hit(paddr, `WIT_CTL_INDEX) &
                    ~wit_hit(paddr, `WIT_STAT_INDEX);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         if (wit_hit(paddr, `WIT_CTL_INDEX)) begin
            prdata <= {24'h000000, key_field, run, mode, sel};
         end else if (wit_hit(paddr, `WIT_STAT_INDEX)) begin
            prdata <= {30'h00000000, doze_miss, key_state == wit_pkg::WIT_KEY_ARMED};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_arm;
      arm_req && !deep;
   endsequence

   sequence s_fire;
      fire_req && !deep;
   endsequence

   a_idle_hold: assert property ((!run && !start_req && !deep) |=> $stable(cnt))
      else $error("Counter moved while disabled");

   a_deep_clear: assert property (deep |=> (cnt == 15'h0000) && $stable(sel))
      else $error("Counter not cleared in deep sleep");

   a_wd_lock: assert property ((run && !mode) |=> (run && !mode))
      else $error("Running watchdog was stopped or changed mode");

   a_start_zero: assert property (start_req |=> run && (cnt == 15'h0000))
      else $error("Start did not run from zero");

   a_wd_bite: assert property ((expire && !mode && awake) |=> sys_reset_req)
      else $error("Watchdog timeout without reset");

   a_key_clear: assert property (s_arm ##[2:40] s_fire |=> (cnt == 15'h0000))
      else $error("Clear sequence did not clear counter");

   a_key_lapse: assert property ((key_lapse && !mode && awake) |=> sys_reset_req)
      else $error("Lapsed clear sequence without reset");

   a_key_ignore: assert property ((ctl_wr && !run) |=> $stable(key_field))
      else $error("Clear key taken while disabled");

   a_wd_no_irq: assert property ((timeout_flag || irq_req) |-> $past(mode))
      else $error("Interrupt raised in watchdog mode");

   a_timer_wrap: assert property ((expire && mode) |=> timeout_flag && (cnt == 15'h0000))
      else $error("Timer expiry did not flag and wrap");

   a_timer_clear: assert property (tclear_req |=> (cnt == 15'h0000))
      else $error("Timer clear bit did not clear counter");

   a_timer_quiet: assert property (sys_reset_req |-> !mode)
      else $error("Reset requested in timer mode");

   a_doze_quiet: assert property ((doze)[*2] |-> !sys_reset_req)
      else $error("Reset requested in first sleep level");

   a_doze_wake: assert property ((doze_miss && awake) |=> sys_reset_req)
      else $error("Deferred timeout not acted on at wake");

endmodule : wit_watchdog

/* wit_watchdog_bench.sv */
`timescale 1ns/1ps
`include "wit_defines.svh"
module wit_watchdog_bench;
   localparam logic [11:0] CTL = {`WIT_CTL_INDEX, 2'h0};
   localparam logic [11:0] STAT = {`WIT_STAT_INDEX, 2'h0};
   localparam int LS = 1020;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic lsclk = 1'h0;
   logic [2:0] pwr_mode = 3'h0;
   logic timeout_irq_allow = 1'h1;
   logic [31:0] prdata;
   logic pready, pslverr, timeout_flag, irq_req, sys_reset_req, err;
   logic [31:0] rd;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int n_rst = 0;
   int n_flag = 0;
   int n_irq = 0;
   int nb, nq;
   time t_flag, t_rst, t1;

   always #25 pclk = ~pclk;
   always #510 lsclk = ~lsclk;

   wit_watchdog wit_watchdog_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lsclk(lsclk), .pwr_mode(pwr_mode),
      .timeout_irq_allow(timeout_irq_allow), .timeout_flag(timeout_flag), .irq_req(irq_req),
      .sys_reset_req(sys_reset_req));

   // ----------------------------------------
   // Pulse counters and run limit
   // ----------------------------------------
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (timeout_flag === 1'h1) begin
         n_flag <= n_flag + 1;
         t_flag <= $time;
      end
      if (sys_reset_req === 1'h1) begin
         n_rst <= n_rst + 1;
         t_rst <= $time;
      end
      if (irq_req === 1'h1) n_irq <= n_irq + 1;
      if (cyc == 80000) begin
         n_errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                        input int tol);
      checked++;
      if ((got > exp + tol) !== 1'h0 || (got + tol < exp) !== 1'h0) begin
         n_errors++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      check("pready", 1, n, 0);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_ls(input int ticks);
      repeat (ticks) @(posedge lsclk);
      @(posedge pclk);
   endtask : wait_ls

   task automatic await(input logic rst, input int lim);
      int n, base;
      base = rst ? n_rst : n_flag;
      n = 0;
      while ((rst ? n_rst : n_flag) == base && n < lim) begin
         @(posedge pclk);
         n++;
      end
      check("pulse wait", 0, n / lim, 0);
   endtask : await

   task automatic key_seq(input logic full);
      @(posedge lsclk);
      repeat (4) @(posedge pclk);
      apb(1'h1, CTL, 8'hAB);
      if (full) apb(1'h1, CTL, 8'h5B);
   endtask : key_seq

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, CTL, 8'h00);
      check("ctl reset", 0, rd, 0);
      apb(1'h0, 12'h3FC, 8'h00);
      check("unmapped", 1, {31'h0, err}, 0);
      apb(1'h1, CTL, 8'hA0);
      apb(1'h0, CTL, 8'h00);
      check("key run0", 0, rd, 0);
      wait_ls(80);
      check("idle pulses", 0, n_flag + n_rst + n_irq, 0);
      $display("test reset done");
      for (int s = 3; s >= 2; s--) begin
         timeout_irq_allow <= (s == 3);
         apb(1'h1, CTL, 8'h0C | 8'(s));
         nb = n_irq;
         await(1'h0, 12000);
         t1 = t_flag;
         await(1'h0, 12000);
         check("interval", (s == 3 ? 64 : 512) * LS, 32'(t_flag - t1), 100);
         check("irq", nb + (s == 3 ? 2 : 0), n_irq, 0);
      end
      apb(1'h1, CTL, 8'h0F);
      wait_ls(30);
      t1 = $time;
      apb(1'h1, CTL, 8'h1F);
      await(1'h0, 1500);
      check("timer clear", 64 * LS, 32'(t_flag - t1), 660);
      apb(1'h1, CTL, 8'h07);
      nb = n_flag;
      wait_ls(100);
      check("timer stop", nb, n_flag, 0);
      t1 = $time;
      apb(1'h1, CTL, 8'h0F);
      await(1'h0, 1500);
      check("restart", 64 * LS, 32'(t_flag - t1), 660);
      apb(1'h1, CTL, 8'h07);
      check("timer no reset", 0, n_rst, 0);
      $display("test timer done");
      apb(1'h1, CTL, 8'h0B);
      nq = n_flag + n_irq;
      apb(1'h1, CTL, 8'h00);
      apb(1'h1, CTL, 8'h06);
      apb(1'h0, CTL, 8'h00);
      check("wd lock", 4'hA, rd[3:0], 0);
      apb(1'h1, CTL, 8'h0B);
      t1 = n_rst;
      repeat (4) begin
         key_seq(1'h1);
         wait_ls(40);
      end
      check("cleared", 32'(t1), n_rst, 0);
      await(1'h1, 1500);
      t1 = t_rst;
      await(1'h1, 1500);
      check("wd interval", 64 * LS, 32'(t_rst - t1), 100);
      key_seq(1'h0);
      await(1'h1, 30);
      pwr_mode <= 3'h3;
      nb = n_rst;
      wait_ls(70);
      pwr_mode <= 3'h4;
      wait_ls(70);
      check("deep no reset", nb, n_rst, 0);
      pwr_mode <= 3'h0;
      t1 = $time;
      apb(1'h0, CTL, 8'h00);
      check("deep config", 4'hB, rd[3:0], 0);
      await(1'h1, 1500);
      check("deep restart", 64 * LS - 510, 32'(t_rst - t1), 660);
      pwr_mode <= 3'h2;
      nb = n_rst;
      wait_ls(80);
      check("level one", nb, n_rst, 0);
      apb(1'h0, STAT, 8'h00);
      check("pending", 2, rd, 0);
      pwr_mode <= 3'h0;
      await(1'h1, 4);
      pwr_mode <= 3'h1;
      await(1'h1, 1500);
      check("wd no irq", nq, n_flag + n_irq, 0);
      $display("test watchdog done");
      end_sim();
   end
endmodule : wit_watchdog_bench
